/* acl_defs.vh */
/*
 * Shared constants for the cascadable front-end serial link: word layout,
 * channel count, control word fields and synchroniser width.
 * Assumes it is included by bare name from the design file of the link.
 */
`ifndef ACL_DEFS_VH
`define ACL_DEFS_VH

// Bits in one conversion result or control word.
`define ACL_WORD_BITS 16
// Width of the bit counter, enough for one word.
`define ACL_BIT_CW 4
// Index of the last bit of a word.
`define ACL_BIT_LAST 4'hF
// Conversion channels delivered per sample period.
`define ACL_CHANNELS 6
// Width of the word counter.
`define ACL_WORD_CW 3
// Index of the last channel word in a frame.
`define ACL_WORD_LAST 3'h5
// Width of the latched sample set, six words of sixteen bits.
`define ACL_SET_BITS 96
// Control flag: a set top bit marks a control word, clear marks data.
`define ACL_CTRL_BIT 15
// Device address field of a control word.
`define ACL_ADDR_MSB 14
`define ACL_ADDR_LSB 12
`define ACL_ADDR_W 3
// Software reset request bit of a control word.
`define ACL_SRST_BIT 11
// Number of pin inputs taken through the synchroniser.
`define ACL_SYNC_W 5
// Positions of the pins inside the synchroniser vector.
`define ACL_SY_MCLK 0
`define ACL_SY_PEN 1
`define ACL_SY_RSTN 2
`define ACL_SY_DIN 3
`define ACL_SY_IFS 4
// Reset value of the synchroniser stages: reset pin idle high.
`define ACL_SYNC_RST 5'h04

`endif

/* acl_link.v */
/*
 * Serial port logic of one six-channel front end that can sit alone or in
 * a cascade. It drives the serial clock, sends six conversion words per
 * sample period, then passes the upstream device's words through, and
 * decodes control words addressed to it.
 * Assumes: the master clock, port enable, reset, data in and in-frame
 * sync arrive as pins from outside the clk domain; the master clock is
 * much slower than clk; sample_strobe and sample_data come from the
 * converters on clk; the host keeps frame timing within cascade limits.
 */
`include "acl_defs.vh"

module acl_link #(
    // Address strap of this device in the cascade.
    parameter [`ACL_ADDR_W-1:0] DEV_ADDR = 3'h0
) (
    clk,
    sys_rst,
    afe_master_clock,
    afe_port_enable,
    afe_reset_n,
    mixed_mode,
    afe_data_in,
    afe_in_frame_sync,
    sample_strobe,
    sample_data,
    afe_serial_clock,
    afe_data_out,
    afe_out_frame_sync,
    ctrl_word,
    ctrl_word_valid,
    soft_reset_pulse,
    frame_busy
);
    input wire clk;
    input wire sys_rst;
    input wire afe_master_clock;
    input wire afe_port_enable;
    input wire afe_reset_n;
    input wire mixed_mode;
    input wire afe_data_in;
    input wire afe_in_frame_sync;
    input wire sample_strobe;
    input wire [`ACL_SET_BITS-1:0] sample_data;
    output reg afe_serial_clock;
    output reg afe_data_out;
    output reg afe_out_frame_sync;
    output reg [`ACL_WORD_BITS-1:0] ctrl_word;
    output reg ctrl_word_valid;
    output reg soft_reset_pulse;
    output reg frame_busy;

    // Transmit states: forwarding upstream data, or sending own words.
    localparam ST_PASS = 1'b0;
    localparam ST_SEND = 1'b1;

    // Three synchroniser stages; stage one is read only by stage two.
    reg [`ACL_SYNC_W-1:0] sy1_r;
    reg [`ACL_SYNC_W-1:0] sy2_r;
    reg [`ACL_SYNC_W-1:0] sy3_r;
    // Settled pin levels, updated only when stages two and three agree.
    reg [`ACL_SYNC_W-1:0] pin_r;
    wire [`ACL_SYNC_W-1:0] agree;
    wire [`ACL_SYNC_W-1:0] pin_nxt;
    // Previous settled master clock level, for rising edge detection.
    reg mclk_prev_r;
    wire mclk_rise;
    // Serial clock ticks: the edge that launches and the edge that samples.
    wire launch_tick;
    wire sample_tick;
    // Core reset: system reset, reset pin or a software reset.
    wire core_rst;

    // Latched sample set and its pending flag.
    reg [`ACL_SET_BITS-1:0] set_r;
    reg pending_r;
    reg state_r;
    reg [`ACL_BIT_CW-1:0] bit_r;
    reg [`ACL_WORD_CW-1:0] word_r;
    // Upstream bits taken on the sampling edge, used when forwarding.
    reg din_smp_r;
    reg ifs_smp_r;
    // Receiver of control words arriving on the data input.
    reg rx_act_r;
    reg [`ACL_BIT_CW-1:0] rx_cnt_r;
    reg [`ACL_WORD_BITS-1:0] rx_sh_r;

    assign agree = ~(sy2_r ^ sy3_r);
    assign pin_nxt = (agree & sy3_r) | (~agree & pin_r);
    assign mclk_rise = pin_r[`ACL_SY_MCLK] & ~mclk_prev_r;
    // The serial clock runs at half the master rate, only while enabled.
    assign launch_tick = mclk_rise & ~afe_serial_clock &
        pin_r[`ACL_SY_PEN];
    assign sample_tick = mclk_rise & afe_serial_clock;
    assign core_rst = sys_rst | ~pin_r[`ACL_SY_RSTN] | soft_reset_pulse;

    // Synchroniser and settled levels; the reset pin only takes effect
    // through this path, so a glitch shorter than two clocks is ignored.
    always @(posedge clk) begin
        if (sys_rst) begin
            sy1_r <= `ACL_SYNC_RST;
            sy2_r <= `ACL_SYNC_RST;
            sy3_r <= `ACL_SYNC_RST;
            pin_r <= `ACL_SYNC_RST;
            mclk_prev_r <= 1'b0;
        end else begin
            sy1_r <= {afe_in_frame_sync, afe_data_in, afe_reset_n,
                afe_port_enable, afe_master_clock};
            sy2_r <= sy1_r;
            sy3_r <= sy2_r;
            pin_r <= pin_nxt;
            mclk_prev_r <= pin_r[`ACL_SY_MCLK];
        end
    end

    // Serial clock generation from master clock edges. With the port
    // disabled the clock parks low, which powers the serial port down.
    always @(posedge clk) begin
        if (core_rst) begin
            afe_serial_clock <= 1'b0;
        end else if (launch_tick) begin
            afe_serial_clock <= 1'b1;
        end else if (sample_tick) begin
            afe_serial_clock <= 1'b0;
        end
    end

    // Sample set capture; a new strobe while a frame is pending simply
    // replaces the older set, since the older one is already stale.
    always @(posedge clk) begin
        if (core_rst) begin
            set_r <= {`ACL_SET_BITS{1'b0}};
            pending_r <= 1'b0;
        end else if (sample_strobe) begin
            set_r <= sample_data;
            pending_r <= 1'b1;
        end else if (launch_tick && state_r == ST_PASS && pending_r) begin
            pending_r <= 1'b0;
        end
    end

    // Upstream bits are taken on the falling serial clock edge, half a
    // period after the upstream device launched them.
    always @(posedge clk) begin
        if (core_rst) begin
            din_smp_r <= 1'b0;
            ifs_smp_r <= 1'b0;
        end else if (sample_tick) begin
            din_smp_r <= pin_r[`ACL_SY_DIN];
            ifs_smp_r <= pin_r[`ACL_SY_IFS];
        end
    end

    // Transmit machine. Own words go first, most significant bit first,
    // with the frame sync high during the first bit of each word.
    // Upstream words that arrive while own words are sent are lost; the
    // frame timing bound on the host side keeps this from happening.
    always @(posedge clk) begin
        if (core_rst) begin
            state_r <= ST_PASS;
            bit_r <= 4'h0;
            word_r <= 3'h0;
            afe_data_out <= 1'b0;
            afe_out_frame_sync <= 1'b0;
            frame_busy <= 1'b0;
        end else if (launch_tick) begin
            case (state_r)
                ST_PASS: begin
                    if (pending_r) begin
                        state_r <= ST_SEND;
                        bit_r <= 4'h1;
                        word_r <= 3'h0;
                        frame_busy <= 1'b1;
                        afe_data_out <= set_r[`ACL_SET_BITS-1];
                        afe_out_frame_sync <= 1'b1;
                    end else begin
                        afe_data_out <= din_smp_r;
                        afe_out_frame_sync <= ifs_smp_r;
                    end
                end
                ST_SEND: begin
                    afe_data_out <= set_r[`ACL_SET_BITS-1 -
                        (word_r * `ACL_WORD_BITS + bit_r)];
                    afe_out_frame_sync <= (bit_r == 4'h0);
                    bit_r <= bit_r + 4'h1;
                    if (bit_r == `ACL_BIT_LAST) begin
                        if (word_r == `ACL_WORD_LAST) begin
                            state_r <= ST_PASS;
                            frame_busy <= 1'b0;
                        end else begin
                            word_r <= word_r + 3'h1;
                        end
                    end
                end
                default: begin
                    state_r <= ST_PASS;
                end
            endcase
        end
    end

    // Control word receiver. A word starts with the in-frame sync on its
    // first bit; words pass on downstream unchanged either way, except one that
    // fires a soft reset, so every device sees every word and picks its own by address.
    always @(posedge clk) begin
        if (core_rst) begin
            rx_act_r <= 1'b0;
            rx_cnt_r <= 4'h0;
            rx_sh_r <= 16'h0000;
        end else if (sample_tick) begin
            if (!rx_act_r && pin_r[`ACL_SY_IFS]) begin
                rx_act_r <= 1'b1;
                rx_cnt_r <= 4'h1;
                rx_sh_r <= {15'h0000, pin_r[`ACL_SY_DIN]};
            end else if (rx_act_r) begin
                rx_sh_r <= {rx_sh_r[`ACL_WORD_BITS-2:0], pin_r[`ACL_SY_DIN]};
                rx_cnt_r <= rx_cnt_r + 4'h1;
                if (rx_cnt_r == `ACL_BIT_LAST) begin
                    rx_act_r <= 1'b0;
                end
            end
        end
    end

    // Decode of a completed word. The shifter holds all sixteen bits only
    // after the sampling edge that took the last one, hence this flag.
    reg rx_done_r;
    always @(posedge clk) begin
        if (core_rst) begin
            rx_done_r <= 1'b0;
        end else begin
            rx_done_r <= sample_tick & rx_act_r & (rx_cnt_r == `ACL_BIT_LAST);
        end
    end

    // Control word outputs. A software reset only acts in mixed mode; it
    // is the sole reset path when the reset pin is tied to system reset.
    always @(posedge clk) begin
        if (sys_rst || !pin_r[`ACL_SY_RSTN]) begin
            ctrl_word <= 16'h0000;
            ctrl_word_valid <= 1'b0;
            soft_reset_pulse <= 1'b0;
        end else begin
            ctrl_word_valid <= 1'b0;
            soft_reset_pulse <= 1'b0;
            if (rx_done_r && rx_sh_r[`ACL_CTRL_BIT] &&
                rx_sh_r[`ACL_ADDR_MSB:`ACL_ADDR_LSB] == DEV_ADDR) begin
                ctrl_word <= rx_sh_r;
                ctrl_word_valid <= 1'b1;
                soft_reset_pulse <= mixed_mode & rx_sh_r[`ACL_SRST_BIT];
            end
        end
    end
endmodule

/* acl_unused_check.v */
/*
 * Holds no logic: the whole serial link lives in acl_link.v.
 * Assumes nothing of its surroundings.
 */

/* acl_link_properties.sv */
/* Port checker for one front end serial link.
   Assumes it is bound onto every acl_link instance. */
module acl_link_props #(
    parameter [2:0] DEV_ADDR = 3'h0
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic mixed_mode,
    input wire logic afe_serial_clock,
    input wire logic afe_data_out,
    input wire logic afe_out_frame_sync,
    input wire logic [15:0] ctrl_word,
    input wire logic ctrl_word_valid,
    input wire logic soft_reset_pulse,
    input wire logic frame_busy
);
    // All checks share the one clock; all but rst_clear_a are disabled by its reset.
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    rst_clear_a: assert property (disable iff (1'b0)
        sys_rst |=> !afe_serial_clock && !afe_out_frame_sync && !frame_busy
        && !ctrl_word_valid && !soft_reset_pulse && ctrl_word == 16'h0000)
        else $error("outputs not cleared by reset");
    valid_pulse_a: assert property (ctrl_word_valid |=> !ctrl_word_valid)
        else $error("control valid longer than one cycle");
    valid_addr_a: assert property (ctrl_word_valid |-> ctrl_word[15]
        && ctrl_word[14:12] == DEV_ADDR) else $error("foreign word taken");
    word_hold_a: assert property ($changed(ctrl_word) |->
        ctrl_word_valid || ctrl_word == 16'h0000)
        else $error("control word moved without valid");
    srst_cause_a: assert property (soft_reset_pulse |-> ctrl_word_valid
        && mixed_mode && ctrl_word[11]) else $error("stray soft reset");
    fs_launch_a: assert property ($rose(afe_out_frame_sync) |->
        $rose(afe_serial_clock)) else $error("frame sync off launch edge");
    data_launch_a: assert property ($rose(afe_data_out) |->
        $rose(afe_serial_clock)) else $error("data off launch edge");
    busy_start_a: assert property ($rose(frame_busy) |->
        $rose(afe_serial_clock) && afe_out_frame_sync)
        else $error("frame start without sync");
    busy_end_a: assert property ($fell(frame_busy) |->
        $rose(afe_serial_clock)) else $error("frame end off launch edge");
    sclk_hold_a: assert property ($rose(afe_serial_clock) |=>
        afe_serial_clock [*8]) else $error("serial clock high too short");
    cover property ($rose(frame_busy));
    cover property (ctrl_word_valid);
    cover property (soft_reset_pulse);
endmodule
bind acl_link acl_link_props #(.DEV_ADDR(DEV_ADDR)) u_props (
    .clk(clk), .sys_rst(sys_rst), .mixed_mode(mixed_mode),
    .afe_serial_clock(afe_serial_clock), .afe_data_out(afe_data_out),
    .afe_out_frame_sync(afe_out_frame_sync), .ctrl_word(ctrl_word),
    .ctrl_word_valid(ctrl_word_valid), .soft_reset_pulse(soft_reset_pulse),
    .frame_busy(frame_busy));

/* acl_host_model.sv */
/* Host serial port model: collects words from the front end, sends
   control words, and drives the synced enable and reset pins.
   Assumes the front end supplies the serial clock. */
module acl_host_model (
    input wire logic afe_master_clock,
    input wire logic pen_req,
    input wire logic rst_req_n,
    input wire logic afe_serial_clock,
    input wire logic host_receive_data,
    input wire logic host_rx_frame_sync,
    output logic afe_port_enable,
    output logic afe_reset_n,
    output logic host_transmit_data,
    output logic host_tx_frame_sync
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] rx_words [$]; // Received words in chain order.
    logic [15:0] sh; // Receive shifter.
    int bits = -1; // Bits still due; negative while idle.
    initial begin
        afe_port_enable = 1'b0;
        afe_reset_n = 1'b1;
        host_transmit_data = 1'b0;
        host_tx_frame_sync = 1'b0;
    end
    always @(posedge afe_master_clock) begin
        afe_port_enable <= pen_req;
        afe_reset_n <= rst_req_n;
    end
    always @(negedge afe_serial_clock) begin
        if (host_rx_frame_sync) bits = 15;
        if (bits >= 0) begin
            sh = {sh[14:0], host_receive_data};
            if (bits == 0) rx_words.push_back(sh);
            bits = bits - 1;
        end
    end
    task automatic send_word(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            @(posedge afe_serial_clock);
            host_transmit_data <= w[i];
            host_tx_frame_sync <= (i == 15);
        end
        @(posedge afe_serial_clock);
        host_tx_frame_sync <= 1'b0;
        host_transmit_data <= ~w[0]; // Released line shows no stale bit.
    endtask
endmodule

/* tb_acl_link.sv */
/* Self-checking bench for acl_link with a host port model.
   Assumes the checker and the model are compiled first. */
module tb_acl_link;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, sys_rst = 1, mclk = 0, pen_req = 1, rst_req_n = 1;
    logic mixed_mode = 0, sample_strobe = 0;
    logic [95:0] sample_data = 96'h0;
    wire pen, rstn, din, ifs, sclk, dout, ofs, vld, srst, busy;
    wire [15:0] cw;
    int err_total = 0, n_checks = 0, n_vld = 0, n_srst = 0;
    initial forever #2 clk = ~clk;
    // Master clock has its own phase.
    initial begin
        #1.3;
        forever #62.5 mclk = ~mclk;
    end
    acl_link dut (.clk(clk), .sys_rst(sys_rst), .afe_master_clock(mclk),
        .afe_port_enable(pen), .afe_reset_n(rstn), .mixed_mode(mixed_mode),
        .afe_data_in(din), .afe_in_frame_sync(ifs),
        .sample_strobe(sample_strobe), .sample_data(sample_data),
        .afe_serial_clock(sclk), .afe_data_out(dout),
        .afe_out_frame_sync(ofs), .ctrl_word(cw), .ctrl_word_valid(vld),
        .soft_reset_pulse(srst), .frame_busy(busy));
    acl_host_model host (.afe_master_clock(mclk), .pen_req(pen_req),
        .rst_req_n(rst_req_n), .afe_serial_clock(sclk),
        .host_receive_data(dout), .host_rx_frame_sync(ofs),
        .afe_port_enable(pen), .afe_reset_n(rstn),
        .host_transmit_data(din), .host_tx_frame_sync(ifs));
    // Pulse counters for the one-cycle outputs, read at the falling edge
    // so that they never race the edge that launches the pulse.
    always @(negedge clk) begin
        if (vld === 1'b1) n_vld++;
        if (srst === 1'b1) n_srst++;
    end
    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Bounded wait for received words.
    task automatic wait_words(input int n);
        for (int i = 0; i < 20000 && host.rx_words.size() < n; i++)
            @(negedge clk);
    endtask
    task automatic t_frame(input logic [95:0] d);
        host.rx_words.delete();
        @(negedge clk);
        sample_data = d;
        sample_strobe = 1;
        @(negedge clk);
        sample_strobe = 0;
        repeat (4) @(negedge sclk);
        chk(busy, 1);
        wait_words(6);
        for (int i = 0; i < 6; i++)
            chk(host.rx_words[i], d[95-16*i -: 16]);
        chk(busy, 0);
        // Keep strobes at least six 17-bit slots of one device apart.
        repeat (7) @(negedge sclk);
        $display("t_frame end");
    endtask
    task automatic t_ctrl(input logic [15:0] w, input logic mm,
        input int ev, input int es);
        int v0;
        int s0;
        v0 = n_vld;
        s0 = n_srst;
        mixed_mode = mm;
        host.rx_words.delete();
        host.send_word(w);
        repeat (8) @(negedge clk);
        chk(n_vld - v0, ev);
        chk(n_srst - s0, es);
        if (ev == 1) chk(cw, w);
        wait_words(1);
        if (es == 0) chk(host.rx_words[0], w);
        $display("t_ctrl end");
    endtask
    task automatic t_pen;
        pen_req = 0;
        repeat (300) @(negedge clk);
        chk(sclk, 0);
        repeat (300) @(negedge clk);
        chk(sclk, 0);
        rst_req_n = 0;
        repeat (300) @(negedge clk);
        chk(cw, 0);
        rst_req_n = 1;
        pen_req = 1;
        repeat (300) @(negedge clk);
        $display("t_pen end");
    endtask
    initial begin
        repeat (16) @(negedge clk);
        chk({sclk, dout, ofs, vld, srst, busy, cw}, 0);
        sys_rst = 0;
        t_frame(96'h0123_4567_89AB_CDEF_FFFF_0000);
        t_frame(96'h8000_0001_7FFE_5A5A_C3C3_1111);
        t_ctrl(16'h8123, 0, 1, 0);
        t_ctrl(16'hB456, 0, 0, 0);
        t_ctrl(16'h0FFF, 0, 0, 0);
        t_ctrl(16'h8800, 0, 1, 0);
        t_ctrl(16'h8801, 1, 1, 1);
        t_pen();
        t_frame(96'hFEDC_BA98_7654_3210_AAAA_5555);
        finish_test();
    end
    // Watchdog: the tests need about 110 us, so this leaves ample margin.
    initial begin
        #300us;
        err_total++;
        finish_test();
    end
endmodule
